/* File: pin_sync.sv */
`timescale 1ns/1ps
`default_nettype none
module pin_sync (
  input  wire logic                  clk_sys,
  input  wire logic                  reset,
  input  wire logic                  ce,
  input  wire spi_mem_pkg::pins_type pins_raw,
  output var  spi_mem_pkg::pins_type pins_s,
  output logic                       sck_rise,
  output logic                       sck_fall,
  output logic                       cs_rise
);
  import spi_mem_pkg::*;

  pins_type meta_q;
  pins_type sync_q;
  pins_type prev_q;

  // Two-stage synchroniser plus one delay stage for edge detection
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      meta_q <= PINS_IDLE;
      sync_q <= PINS_IDLE;
      prev_q <= PINS_IDLE;
    end else if (ce) begin
      meta_q <= pins_raw;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  // Edges come from the settled stage only
  assign pins_s   = sync_q;
  assign sck_rise = sync_q.sck & ~prev_q.sck;
  assign sck_fall = ~sync_q.sck & prev_q.sck;
  assign cs_rise  = sync_q.cs_n & ~prev_q.cs_n;

endmodule
`default_nettype wire

/* File: spi_master_model.sv */
`timescale 1ns/1ps
`default_nettype none
// Behavioural bus master; every pin moves only on a clk_sys rising edge
module spi_master_model (
  input  wire logic clk_sys,
  input  wire logic serial_out,
  input  wire logic serial_out_oe,
  output logic      sck,
  output logic      cs_n,
  output logic      serial_in
);
  logic mode3;
  logic oe_seen;

  // Idle bus: deselected, clock parked for mode 0
  initial begin
    mode3     = 1'b0;
    oe_seen   = 1'b0;
    sck       = 1'b0;
    cs_n      = 1'b1;
    serial_in = 1'b0;
  end

  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  // One frame of nbits; half period is 4 clk_sys, so the link runs at 320 ns
  task automatic frame(input logic [63:0] tx, input int nbits, output logic [63:0] rx);
    rx = '0;
    oe_seen = 1'b0;
    sck <= mode3;
    wait_clk(1);
    cs_n <= 1'b0;
    wait_clk(4);
    for (int i = nbits - 1; i >= 0; i--) begin
      sck       <= 1'b0;
      serial_in <= tx[i];
      wait_clk(4);
      sck <= 1'b1;
      wait_clk(3);
      // Sampled late in the high phase, since the port answers a few cycles after the fall;
      // an undriven line reads as the inverse so a late output enable shows up
      rx[i] = serial_out_oe ? serial_out : ~serial_out;
      oe_seen = oe_seen | serial_out_oe;
      wait_clk(1);
    end
    if (!mode3) begin
      sck <= 1'b0;
    end
    wait_clk(2);
    cs_n <= 1'b1;
    // Released data line shows the inverse, never a stale level
    serial_in <= ~serial_in;
    wait_clk(6);
  endtask
endmodule
`default_nettype wire

/* File: spi_mem_pkg.sv */
`default_nettype none
package spi_mem_pkg;

  // Opcodes recognised by the instruction decoder
  localparam logic [7:0] write_cmd          = 8'h02;
  localparam logic [7:0] read_cmd           = 8'h03;
  localparam logic [7:0] fast_read_cmd      = 8'h0b;
  localparam logic [7:0] write_disable_cmd  = 8'h04;
  localparam logic [7:0] status_read_cmd    = 8'h05;
  localparam logic [7:0] write_enable_cmd   = 8'h06;
  localparam logic [7:0] page_erase_cmd     = 8'h42;
  localparam logic [7:0] chip_erase_cmd     = 8'h60;
  localparam logic [7:0] chip_erase_alt_cmd = 8'hc7;
  localparam logic [7:0] power_down_cmd     = 8'hb9;
  localparam logic [7:0] wake_cmd           = 8'hab;
  // Marks an ignored or absent instruction
  localparam logic [7:0] no_cmd             = 8'h00;

  // Status register layout and reset values
  localparam int         BUSY_POS    = 0;
  localparam int         LATCH_POS   = 1;
  localparam logic [5:0] STATUS_PAD  = 6'h00;
  localparam logic       LATCH_RESET = 1'b0;
  localparam logic       SLEEP_RESET = 1'b0;

  // Array geometry
  localparam int                   MEM_ADDR_W = 12;
  localparam int                   PAGE_BITS  = 5;
  localparam logic [PAGE_BITS-1:0] PAGE_STEP  = 5'h01;
  localparam logic [5:0]           PAGE_BYTES = 6'h20;

  // Frame sequencer states
  typedef enum logic [6:0] {
    ST_OPCODE = 7'b0000001,
    ST_ADDR   = 7'b0000010,
    ST_DUMMY  = 7'b0000100,
    ST_READ   = 7'b0001000,
    ST_STATUS = 7'b0010000,
    ST_WRITE  = 7'b0100000,
    ST_IGNORE = 7'b1000000
  } state_type;

  // Serial pins as sampled
  typedef struct packed {
    logic sck;
    logic cs_n;
    logic serial_in;
  } pins_type;

  // Idle levels: clock low, chip deselected
  localparam pins_type PINS_IDLE = 3'h2;

  // Request towards the memory array
  typedef struct packed {
    logic [15:0] addr;
    logic [7:0]  data;
    logic        rd;
    logic        load;
  } mem_req_type;

endpackage
`default_nettype wire

/* File: spi_mem_port.sv */
`timescale 1ns/1ps
`default_nettype none
module spi_mem_port #(
  parameter int ADDR_W = spi_mem_pkg::MEM_ADDR_W
) (
  input  wire logic                     clk_sys,
  input  wire logic                     reset,
  input  wire logic                     ce,
  input  wire logic                     sck,
  input  wire logic                     cs_n,
  input  wire logic                     serial_in,
  input  wire logic                     array_busy,
  input  wire logic [7:0]               mem_rd_data,
  output logic                          serial_out,
  output logic                          serial_out_oe,
  output var  spi_mem_pkg::mem_req_type mem_req,
  output logic                          program_start,
  output logic                          page_erase_start,
  output logic                          chip_erase_start,
  output logic                          power_down,
  output logic [7:0]                    device_status
);
  import spi_mem_pkg::*;

  pins_type    pins_raw;
  pins_type    pins_s;
  logic        sck_rise;
  logic        sck_fall;
  logic        cs_rise;
  state_type   state_q;
  logic [2:0]  bit_cnt_q;
  logic [7:0]  shift_q;
  logic [7:0]  op_q;
  logic        second_q;
  logic        addr_done_q;
  logic [15:0] addr_q;
  logic [5:0]  data_cnt_q;
  logic        rd_pend_q;
  logic [7:0]  tx_q;
  logic        tx_valid_q;
  logic        latch_q;
  logic        sleep_q;
  logic        frame;
  logic        byte_done;
  logic        clean;
  logic        out_pick;
  logic        sending;
  logic [7:0]  new_byte;
  logic [7:0]  status_now;

  // Keep only the implemented address bits so reads wrap at the top
  function automatic logic [15:0] mask_addr(input logic [15:0] a);
    mask_addr = a & ((16'h0001 << ADDR_W) - 16'h0001);
  endfunction

  // Which opcodes may start now, given busy and power-down
  function automatic logic accept_op(input logic [7:0] op, input logic busy,
                                     input logic sleep);
    if (sleep) begin
      accept_op = (op == wake_cmd);
    end else if (busy) begin
      accept_op = (op == status_read_cmd);
    end else begin
      case (op)
        write_cmd, read_cmd, fast_read_cmd, write_disable_cmd,
        status_read_cmd, write_enable_cmd, page_erase_cmd, chip_erase_cmd,
        chip_erase_alt_cmd, power_down_cmd, wake_cmd: accept_op = 1'b1;
        default: accept_op = 1'b0;
      endcase
    end
  endfunction

  // Phase that follows an accepted opcode
  function automatic state_type op_state(input logic [7:0] op);
    case (op)
      write_cmd, read_cmd, fast_read_cmd, page_erase_cmd: op_state = ST_ADDR;
      status_read_cmd: op_state = ST_STATUS;
      default: op_state = ST_IGNORE;
    endcase
  endfunction

  assign pins_raw = '{sck: sck, cs_n: cs_n, serial_in: serial_in};

  pin_sync u_pin_sync (
    .clk_sys  (clk_sys),
    .reset    (reset),
    .ce       (ce),
    .pins_raw (pins_raw),
    .pins_s   (pins_s),
    .sck_rise (sck_rise),
    .sck_fall (sck_fall),
    .cs_rise  (cs_rise)
  );

  // Frame qualifiers shared by every process below
  assign frame      = ~pins_s.cs_n;
  assign byte_done  = ce & frame & sck_rise & (bit_cnt_q == 3'h7);
  assign new_byte   = {shift_q[6:0], pins_s.serial_in};
  assign clean      = (bit_cnt_q == 3'h0);
  assign status_now = {STATUS_PAD, latch_q, array_busy};
  assign out_pick   = tx_q[3'h7 - bit_cnt_q];
  assign sending    = (state_q == ST_READ) || (state_q == ST_STATUS);

  // Input shifter; deselect holds it idle so input is ignored
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      bit_cnt_q <= 3'h0;
      shift_q   <= 8'h00;
    end else if (ce) begin
      if (!frame) begin
        bit_cnt_q <= 3'h0;
      end else if (sck_rise) begin
        shift_q   <= new_byte;
        bit_cnt_q <= bit_cnt_q + 3'h1;
      end
    end
  end

  // Frame sequencer: opcode, address, dummy, then data phase
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      state_q     <= ST_OPCODE;
      op_q        <= no_cmd;
      second_q    <= 1'b0;
      addr_done_q <= 1'b0;
    end else if (ce) begin
      if (!frame) begin
        state_q     <= ST_OPCODE;
        op_q        <= no_cmd;
        second_q    <= 1'b0;
        addr_done_q <= 1'b0;
      end else if (byte_done) begin
        unique case (state_q)
          ST_OPCODE: begin
            if (accept_op(new_byte, array_busy, sleep_q)) begin
              op_q    <= new_byte;
              state_q <= op_state(new_byte);
            end else begin
              op_q    <= no_cmd;
              state_q <= ST_IGNORE;
            end
          end
          ST_ADDR: begin
            second_q <= 1'b1;
            if (second_q) begin
              addr_done_q <= 1'b1;
              case (op_q)
                read_cmd:      state_q <= ST_READ;
                fast_read_cmd: state_q <= ST_DUMMY;
                write_cmd:     state_q <= ST_WRITE;
                default:       state_q <= ST_IGNORE;
              endcase
            end
          end
          ST_DUMMY: state_q <= ST_READ;
          // Data phases hold until deselect; read input is dropped
          ST_READ, ST_STATUS, ST_WRITE, ST_IGNORE: state_q <= state_q;
        endcase
      end
    end
  end

  // Address counter: linear with wrap for reads, page-local for writes
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      addr_q <= 16'h0000;
    end else if (ce && byte_done) begin
      if (state_q == ST_ADDR) begin
        addr_q <= {addr_q[7:0], new_byte};
      end else if (state_q == ST_READ) begin
        addr_q <= mask_addr(addr_q + 16'h0001);
      end else if (state_q == ST_WRITE && latch_q) begin
        addr_q[PAGE_BITS-1:0] <= addr_q[PAGE_BITS-1:0] + PAGE_STEP;
      end
    end
  end

  // Array requests; each strobe lasts one enabled cycle
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      mem_req   <= '0;
      rd_pend_q <= 1'b0;
    end else if (ce) begin
      mem_req.rd   <= 1'b0;
      mem_req.load <= 1'b0;
      rd_pend_q    <= mem_req.rd;
      if (byte_done) begin
        if (state_q == ST_ADDR && second_q && op_q == read_cmd) begin
          mem_req.rd   <= 1'b1;
          mem_req.addr <= mask_addr({addr_q[7:0], new_byte});
        end else if (state_q == ST_DUMMY) begin
          mem_req.rd   <= 1'b1;
          mem_req.addr <= mask_addr(addr_q);
        end else if (state_q == ST_READ) begin
          mem_req.rd   <= 1'b1;
          mem_req.addr <= mask_addr(addr_q + 16'h0001);
        end else if (state_q == ST_WRITE && latch_q) begin
          mem_req.load <= 1'b1;
          mem_req.addr <= mask_addr(addr_q);
          mem_req.data <= new_byte;
        end
      end
    end
  end

  // Count written bytes; saturates at a full page since extras wrap
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      data_cnt_q <= 6'h00;
    end else if (ce) begin
      if (!frame) begin
        data_cnt_q <= 6'h00;
      end else if (byte_done && state_q == ST_WRITE && latch_q
                   && data_cnt_q != PAGE_BYTES) begin
        data_cnt_q <= data_cnt_q + 6'h01;
      end
    end
  end

  // Output byte: array data a cycle after the request, or live status
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      tx_q       <= 8'h00;
      tx_valid_q <= 1'b0;
    end else if (ce) begin
      if (!frame) begin
        tx_valid_q <= 1'b0;
      end else if (rd_pend_q) begin
        tx_q       <= mem_rd_data;
        tx_valid_q <= 1'b1;
      end else if (byte_done && (state_q == ST_STATUS ||
                   (state_q == ST_OPCODE && op_state(new_byte) == ST_STATUS
                    && accept_op(new_byte, array_busy, sleep_q)))) begin
        tx_q       <= status_now;
        tx_valid_q <= 1'b1;
      end
    end
  end

  // Serial output changes only on falling edges in a data phase and clears at deselect; in mode 3
  // the falling edge right after select finds the opcode phase and is skipped
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      serial_out    <= 1'b0;
      serial_out_oe <= 1'b0;
    end else if (ce) begin
      if (!frame) begin
        serial_out    <= 1'b0;
        serial_out_oe <= 1'b0;
      end else if (sck_fall && tx_valid_q && sending) begin
        serial_out    <= out_pick;
        serial_out_oe <= 1'b1;
      end
    end
  end

  // Write enable latch, power-down and the commit strobes at deselect
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      latch_q          <= LATCH_RESET;
      sleep_q          <= SLEEP_RESET;
      program_start    <= 1'b0;
      page_erase_start <= 1'b0;
      chip_erase_start <= 1'b0;
    end else if (ce) begin
      program_start    <= 1'b0;
      page_erase_start <= 1'b0;
      chip_erase_start <= 1'b0;
      // Wake acts on the eighth rising edge, not on deselect
      if (byte_done && state_q == ST_OPCODE && sleep_q && new_byte == wake_cmd) begin
        sleep_q <= 1'b0;
      end
      // A partial byte at deselect leaves everything untouched
      if (cs_rise && clean) begin
        case (op_q)
          write_enable_cmd: latch_q <= 1'b1;
          write_disable_cmd: latch_q <= 1'b0;
          write_cmd: begin
            if (latch_q && data_cnt_q != 6'h00) begin
              program_start <= 1'b1;
              latch_q       <= 1'b0;
            end
          end
          page_erase_cmd: begin
            if (latch_q && addr_done_q) begin
              page_erase_start <= 1'b1;
              latch_q          <= 1'b0;
            end
          end
          chip_erase_cmd, chip_erase_alt_cmd: begin
            if (latch_q) begin
              chip_erase_start <= 1'b1;
              latch_q          <= 1'b0;
            end
          end
          power_down_cmd: begin
            sleep_q <= 1'b1;
            latch_q <= 1'b0;
          end
          default: ;
        endcase
      end
    end
  end

  // Registered status image for the array side
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      device_status <= 8'h00;
    end else if (ce) begin
      device_status <= status_now;
    end
  end

  assign power_down = sleep_q;

  a_oe_idle: assert property (@(posedge clk_sys) disable iff (reset)
    ($past(ce) && !$past(frame)) |-> !serial_out_oe)
    else $error("output enabled while deselected");

  a_status_bits: assert property (@(posedge clk_sys) disable iff (reset)
    $past(ce) |-> (device_status[7:2] == STATUS_PAD
                   && device_status[LATCH_POS] == $past(latch_q)
                   && device_status[BUSY_POS] == $past(array_busy)))
    else $error("status image wrong");

  a_latch_set: assert property (@(posedge clk_sys) disable iff (reset)
    (ce && cs_rise && clean && op_q == write_enable_cmd) |=> latch_q)
    else $error("write enable did not set latch");

  a_latch_keep: assert property (@(posedge clk_sys) disable iff (reset)
    (ce && cs_rise && !clean) |=> (latch_q == $past(latch_q)))
    else $error("partial byte changed latch");

  a_latch_clear: assert property (@(posedge clk_sys) disable iff (reset)
    (ce && cs_rise && clean && (op_q == write_disable_cmd
     || op_q == power_down_cmd)) |=> !latch_q)
    else $error("latch not cleared");

  a_prog_latch: assert property (@(posedge clk_sys) disable iff (reset)
    $rose(program_start) |-> ($past(latch_q) && !latch_q))
    else $error("program started without latch");

  a_busy_gate: assert property (@(posedge clk_sys) disable iff (reset)
    (byte_done && state_q == ST_OPCODE && !sleep_q && array_busy
     && new_byte != status_read_cmd) |=> (op_q == no_cmd && state_q == ST_IGNORE))
    else $error("instruction taken while busy");

  a_sleep_gate: assert property (@(posedge clk_sys) disable iff (reset)
    (byte_done && state_q == ST_OPCODE && sleep_q && new_byte != wake_cmd)
    |=> (op_q == no_cmd && sleep_q))
    else $error("instruction taken in power-down");

  a_read_next: assert property (@(posedge clk_sys) disable iff (reset)
    (byte_done && state_q == ST_READ)
    |=> (mem_req.rd && mem_req.addr == mask_addr($past(addr_q) + 16'h0001)))
    else $error("read address not advanced");

  a_out_bit: assert property (@(posedge clk_sys) disable iff (reset)
    (ce && frame && sck_fall && tx_valid_q && sending)
    |=> (serial_out_oe && serial_out == $past(out_pick)))
    else $error("wrong output bit");

  a_status_loop: assert property (@(posedge clk_sys) disable iff (reset)
    (byte_done && state_q == ST_STATUS) |=> (tx_q == $past(status_now)))
    else $error("status not reloaded");

endmodule
`default_nettype wire

/* File: tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHECK_EQ(got, exp) begin \
  n_checks++; \
  if ((got) !== (exp)) begin \
    n_mismatch++; \
    $display("[FAIL] %0t ns: got %h expected %h", $time, got, exp); \
  end \
end
module tb_top;
  import spi_mem_pkg::*;

  localparam int LIMIT = 40000;

  logic        clk_sys;
  logic        reset;
  logic        ce;
  logic        sck;
  logic        cs_n;
  logic        serial_in;
  logic        array_busy;
  logic [7:0]  mem_rd_data;
  logic        serial_out;
  logic        serial_out_oe;
  mem_req_type mem_req;
  logic        program_start;
  logic        page_erase_start;
  logic        chip_erase_start;
  logic        power_down;
  logic [7:0]  device_status;
  logic [63:0] rx;
  logic [15:0] last_addr;
  logic [7:0]  last_data;
  int          n_mismatch;
  int          n_checks;
  int          n_load;
  int          n_prog;
  int          n_perase;
  int          n_cerase;
  int          cycles;

  spi_mem_port dut (
    .clk_sys          (clk_sys),
    .reset            (reset),
    .ce               (ce),
    .sck              (sck),
    .cs_n             (cs_n),
    .serial_in        (serial_in),
    .array_busy       (array_busy),
    .mem_rd_data      (mem_rd_data),
    .serial_out       (serial_out),
    .serial_out_oe    (serial_out_oe),
    .mem_req          (mem_req),
    .program_start    (program_start),
    .page_erase_start (page_erase_start),
    .chip_erase_start (chip_erase_start),
    .power_down       (power_down),
    .device_status    (device_status)
  );

  spi_master_model master (
    .clk_sys       (clk_sys),
    .serial_out    (serial_out),
    .serial_out_oe (serial_out_oe),
    .sck           (sck),
    .cs_n          (cs_n),
    .serial_in     (serial_in)
  );

  // Array contents: a pattern that differs between neighbouring addresses, except 7ff/800 and fff/000
  function automatic logic [7:0] data_pattern(input logic [11:0] a);
    return {a[3:0], a[11:8]} ^ a[7:0] ^ 8'h5a;
  endfunction

  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  // Array model with one-cycle read latency, plus strobe counters
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (mem_req.rd === 1'b1) begin
      mem_rd_data <= data_pattern(mem_req.addr[11:0]);
    end
    if (mem_req.load === 1'b1) begin
      n_load    <= n_load + 1;
      last_addr <= mem_req.addr;
      last_data <= mem_req.data;
    end
    if (program_start === 1'b1) n_prog <= n_prog + 1;
    if (page_erase_start === 1'b1) n_perase <= n_perase + 1;
    if (chip_erase_start === 1'b1) n_cerase <= n_cerase + 1;
    if (cycles == LIMIT) begin
      n_mismatch++;
      $display("[FAIL] %0t ns: run took too long", $time);
      stop_test();
    end
  end

  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // Opcode-only frame; no status write opcode is ever sent
  task automatic cmd(input logic [7:0] op);
    master.frame({56'h0, op}, 8, rx);
  endtask

  // Two status bytes in one frame must both match
  task automatic status_exp(input logic [7:0] e);
    master.frame({40'h0, status_read_cmd, 16'h0}, 24, rx);
    `CHECK_EQ(rx[15:8], e)
    `CHECK_EQ(rx[7:0], e)
  endtask

  task automatic t_reset();
    `CHECK_EQ(device_status, 8'h00)
    `CHECK_EQ(serial_out_oe, 1'b0)
    `CHECK_EQ(power_down, 1'b0)
    $display("test reset done");
  endtask

  task automatic t_latch();
    cmd(write_enable_cmd);
    status_exp(8'h02);
    master.mode3 = 1'b1;
    cmd(write_disable_cmd);
    status_exp(8'h00);
    cmd(write_enable_cmd);
    `CHECK_EQ(device_status, 8'h02)
    master.mode3 = 1'b0;
    // Seven bits of the disable opcode: frame must fail
    master.frame({57'h0, 7'h02}, 7, rx);
    status_exp(8'h02);
    cmd(write_disable_cmd);
    $display("test latch done");
  endtask

  task automatic t_read();
    // Upper address nibble kept zero
    master.frame({16'h0, read_cmd, 16'h0ffe, 24'hffffff}, 48, rx);
    `CHECK_EQ(rx[23:16], data_pattern(12'hffe))
    `CHECK_EQ(rx[15:8], data_pattern(12'hfff))
    `CHECK_EQ(rx[7:0], data_pattern(12'h000))
    `CHECK_EQ(serial_out_oe, 1'b0)
    master.frame({24'h0, fast_read_cmd, 16'h0123, 16'h0}, 40, rx);
    `CHECK_EQ(rx[7:0], data_pattern(12'h123))
    $display("test read done");
  endtask

  task automatic t_write();
    cmd(write_enable_cmd);
    master.frame({24'h0, write_cmd, 16'h001f, 16'ha53c}, 40, rx);
    `CHECK_EQ(n_load, 2)
    `CHECK_EQ(last_addr, 16'h0000)
    `CHECK_EQ(last_data, 8'h3c)
    `CHECK_EQ(n_prog, 1)
    status_exp(8'h00);
    master.frame({32'h0, write_cmd, 16'h0040, 8'h11}, 32, rx);
    `CHECK_EQ(n_prog, 1)
    $display("test write done");
  endtask

  task automatic t_erase();
    cmd(write_enable_cmd);
    master.frame({40'h0, page_erase_cmd, 16'h0020}, 24, rx);
    `CHECK_EQ(n_perase, 1)
    status_exp(8'h00);
    cmd(chip_erase_cmd);
    `CHECK_EQ(n_cerase, 0)
    cmd(write_enable_cmd);
    cmd(chip_erase_cmd);
    `CHECK_EQ(n_cerase, 1)
    cmd(write_enable_cmd);
    cmd(chip_erase_alt_cmd);
    `CHECK_EQ(n_cerase, 2)
    status_exp(8'h00);
    $display("test erase done");
  endtask

  task automatic t_busy();
    array_busy <= 1'b1;
    status_exp(8'h01);
    cmd(write_enable_cmd);
    status_exp(8'h01);
    array_busy <= 1'b0;
    status_exp(8'h00);
    // A frame sent while the clock enable is low must leave no trace
    ce <= 1'b0;
    cmd(write_enable_cmd);
    ce <= 1'b1;
    status_exp(8'h00);
    $display("test busy done");
  endtask

  task automatic t_power();
    cmd(write_enable_cmd);
    cmd(power_down_cmd);
    `CHECK_EQ(power_down, 1'b1)
    master.frame({40'h0, status_read_cmd, 16'h0}, 24, rx);
    `CHECK_EQ(master.oe_seen, 1'b0)
    cmd(write_enable_cmd);
    cmd(wake_cmd);
    `CHECK_EQ(power_down, 1'b0)
    status_exp(8'h00);
    // Unknown opcode followed by a status opcode must stay silent
    master.frame({40'h0, 8'h77, status_read_cmd, 8'h00}, 24, rx);
    `CHECK_EQ(master.oe_seen, 1'b0)
    $display("test power done");
  endtask

  // Main sequence: reset held for 12 cycles, then each scenario in turn
  initial begin
    reset       = 1'b1;
    ce          = 1'b1;
    array_busy  = 1'b0;
    mem_rd_data = 8'h00;
    n_mismatch  = 0;
    n_checks    = 0;
    n_load      = 0;
    n_prog      = 0;
    n_perase    = 0;
    n_cerase    = 0;
    cycles      = 0;
    repeat (12) @(posedge clk_sys);
    reset <= 1'b0;
    repeat (4) @(posedge clk_sys);
    t_reset();
    t_latch();
    t_read();
    t_write();
    t_erase();
    t_busy();
    t_power();
    stop_test();
  end
endmodule
`default_nettype wire
